/* core/arcs_cfg.svh */
`ifndef ARCS_CFG_SVH
`define ARCS_CFG_SVH
// =====================================================================
// timing and sizing constants
`define ARCS_CLK_PERIOD_NS    100
`define ARCS_LATENCY_HALF     15
`define ARCS_PIPE_SAMPLES     6
`define ARCS_CAL_NOM_MS       200
`define ARCS_CAL_MAX_MS       550
`define ARCS_CAL_NOM_CYC      ((`ARCS_CAL_NOM_MS * 1000000) / `ARCS_CLK_PERIOD_NS)
`define ARCS_CAL_MAX_CYC      ((`ARCS_CAL_MAX_MS * 1000000) / `ARCS_CLK_PERIOD_NS)
`define ARCS_DLL_LOCK_US      52
`define ARCS_DLL_LOCK_CYC     ((`ARCS_DLL_LOCK_US * 1000 + `ARCS_CLK_PERIOD_NS - 1) / `ARCS_CLK_PERIOD_NS)
`define ARCS_POR_CYC          16
`define ARCS_RECAL_LOW_CYC    1
`define ARCS_DATA_W           10
`endif

/* core/arcs_pkg.sv */
package arcs_pkg;
  // =====================================================================
  // converter sequencing state
  typedef enum logic [1:0] {
    ARCS_POR,
    ARCS_HELD,
    ARCS_CAL,
    ARCS_RUN
  } arcs_state_t;

  // controller view of the calibration
  typedef enum logic [1:0] {
    ARCS_C_IDLE,
    ARCS_C_PULSE,
    ARCS_C_WAIT
  } arcs_ctl_state_t;
endpackage : arcs_pkg

/* core/arcs_link_if.sv */
`timescale 1ns/1ps
interface arcs_link_if;
  // open-drain reset line, wired with device pull-up
  logic dev_reset_low_oe;
  logic ctl_reset_low_oe;
  wire  calibration_reset_n;
  // device outputs
  logic over_range_flag;
  logic output_clock;
  // no net reaches the reserved pins, so they float
  // serial data out line level held by controller pull-up
  logic sdo_pull_high;
  assign calibration_reset_n = ~(dev_reset_low_oe | ctl_reset_low_oe);

  modport device (
    output dev_reset_low_oe,
    input  calibration_reset_n,
    output over_range_flag,
    output output_clock,
    input  sdo_pull_high
  );
  modport controller (
    output ctl_reset_low_oe,
    input  calibration_reset_n,
    input  over_range_flag,
    input  output_clock,
    output sdo_pull_high
  );
endinterface : arcs_link_if

/* core/arcs_device.sv */
`timescale 1ns/1ps
`include "arcs_cfg.svh"
module arcs_device #(
  parameter int unsigned DATA_W  = `ARCS_DATA_W,
  parameter int unsigned CAL_CYC = `ARCS_CAL_NOM_CYC,
  parameter int unsigned LOCK_CYC = `ARCS_DLL_LOCK_CYC,
  parameter int unsigned POR_CYC = `ARCS_POR_CYC
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // link to controller
  arcs_link_if.device            link,
  // user side: converter samples and options
  input  wire logic [DATA_W-1:0] sample_code,
  input  wire logic              div2_enable,
  output logic [DATA_W-1:0]      result_code,
  output logic                   result_valid,
  output logic                   cal_busy,
  output logic                   dll_locked,
  output logic                   cal_fail
);
  import arcs_pkg::*;

  localparam int unsigned HALF_STAGES = `ARCS_LATENCY_HALF;

  // =====================================================================
  // state
  arcs_state_t         state;
  arcs_state_t         next_state;
  logic [31:0]         count;
  logic                reset_q;
  logic                sample_en;
  logic                div_phase;
  logic                div2_q;
  logic [15:0]         lock_count;
  logic [DATA_W-1:0]   pipe [HALF_STAGES];
  logic [HALF_STAGES-1:0] pipe_vld;
  logic                fill_ok;
  logic [3:0]          fill_cnt;

  // =====================================================================
  // decode
  wire reset_low  = ~link.calibration_reset_n;
  wire reset_rise = link.calibration_reset_n & ~reset_q;
  wire full_scale = &sample_code;
  wire cal_done   = (state == ARCS_CAL) && (count >= CAL_CYC - 1);
  wire div_change = div2_enable != div2_q;

  // device drives reset low only in power-on window
  assign link.dev_reset_low_oe = (state == ARCS_POR);
  assign cal_busy   = (state != ARCS_RUN);
  assign dll_locked = (lock_count == 16'h0000);

  // sample enable: every cycle, or every other with the divider
  assign sample_en = div2_q ? div_phase : 1'b1;

  // =====================================================================
  // sequencer transitions
  always_comb
  begin
    next_state = state;
    case (state)
      ARCS_POR:  if (count >= POR_CYC - 1) next_state = ARCS_HELD;
      ARCS_HELD: if (reset_rise) next_state = ARCS_CAL;
      ARCS_CAL:
      begin
        if (reset_low) next_state = ARCS_HELD;
        else if (cal_done) next_state = ARCS_RUN;
      end
      ARCS_RUN:  if (reset_low) next_state = ARCS_HELD;
      default:   next_state = ARCS_POR;
    endcase
  end

  // state register and phase counter
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state   <= ARCS_POR;
      count   <= 32'h0000_0000;
      reset_q <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      reset_q <= link.calibration_reset_n;
      count   <= (next_state != state) ? 32'h0000_0000 : count + 32'h0000_0001;
    end
  end

  // calibration corrupted if serial data out held low
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      cal_fail <= 1'b0;
    else if (reset_rise)
      cal_fail <= 1'b0;
    else if (state == ARCS_CAL && !link.sdo_pull_high)
      cal_fail <= 1'b1;
  end

  // divider and delay-loop relock
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      div_phase  <= 1'b0;
      div2_q     <= 1'b0;
      lock_count <= 16'h0000;
    end
    else
    begin
      div_phase <= div2_q ? ~div_phase : 1'b0;
      div2_q    <= div2_enable;
      if (div_change)
        lock_count <= 16'(LOCK_CYC);
      else if (lock_count != 16'h0000)
        lock_count <= lock_count - 16'h0001;
    end
  end

  // over-range flag and output clock
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      link.over_range_flag <= 1'b1;
      link.output_clock    <= 1'b0;
    end
    else
    begin
      if (reset_low || cal_busy)
        link.over_range_flag <= 1'b1;
      else if (sample_en && pipe_vld[HALF_STAGES-1])
        link.over_range_flag <= &pipe[HALF_STAGES-1];
      if (reset_low)
        link.output_clock <= 1'b0;
      else if (sample_en && dll_locked)
        link.output_clock <= ~link.output_clock;
    end
  end

  // =====================================================================
  // half-cycle latency pipeline, shifted on each output clock edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || reset_low)
    begin
      pipe_vld <= '0;
      fill_cnt <= 4'h0;
    end
    else if (sample_en && dll_locked)
    begin
      pipe_vld <= {pipe_vld[HALF_STAGES-2:0], ~link.output_clock};
      if (fill_cnt != 4'(`ARCS_PIPE_SAMPLES))
        fill_cnt <= fill_cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sample_en && dll_locked)
    begin
      pipe[0] <= full_scale ? {DATA_W{1'b1}} : sample_code; // no wrap
      for (int i = 1; i < HALF_STAGES; i++)
        pipe[i] <= pipe[i-1];
    end
  end

  assign fill_ok = (fill_cnt == 4'(`ARCS_PIPE_SAMPLES));

  // result register
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      result_code  <= '0;
      result_valid <= 1'b0;
    end
    else
    begin
      result_valid <= sample_en && dll_locked && !cal_busy && fill_ok
                      && pipe_vld[HALF_STAGES-1];
      if (sample_en && pipe_vld[HALF_STAGES-1])
        result_code <= pipe[HALF_STAGES-1];
    end
  end
endmodule : arcs_device

/* core/arcs_controller.sv */
`timescale 1ns/1ps
`include "arcs_cfg.svh"
module arcs_controller #(
  parameter int unsigned MAX_CYC   = `ARCS_CAL_MAX_CYC,
  parameter int unsigned PULSE_CYC = `ARCS_RECAL_LOW_CYC
) (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  // link to device
  arcs_link_if.controller link,
  // user side
  input  wire logic   recal_req,
  output logic        cal_done,
  output logic        cal_timeout,
  output logic        spi_allowed
);
  import arcs_pkg::*;

  // =====================================================================
  // state
  arcs_ctl_state_t state;
  logic [31:0]     count;
  logic            reset_q;

  wire reset_rise = link.calibration_reset_n & ~reset_q;

  // keep serial data out pulled high always
  assign link.sdo_pull_high    = 1'b1;
  assign link.ctl_reset_low_oe = (state == ARCS_C_PULSE);
  assign spi_allowed = (state == ARCS_C_IDLE) && cal_done;

  // pulse, then wait for flag fall or timeout
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state       <= ARCS_C_WAIT;
      count       <= 32'h0000_0000;
      reset_q     <= 1'b0;
      cal_done    <= 1'b0;
      cal_timeout <= 1'b0;
    end
    else
    begin
      reset_q <= link.calibration_reset_n;
      count   <= count + 32'h0000_0001;
      case (state)
        ARCS_C_IDLE:
          if (recal_req)
          begin
            state    <= ARCS_C_PULSE;
            count    <= 32'h0000_0000;
            cal_done <= 1'b0;
          end
        ARCS_C_PULSE:
          if (count >= PULSE_CYC - 1)
          begin
            state <= ARCS_C_WAIT;
            count <= 32'h0000_0000;
          end
        ARCS_C_WAIT:
        begin
          if (reset_rise || !link.calibration_reset_n)
            count <= 32'h0000_0000;
          else if (!link.over_range_flag)
          begin
            state       <= ARCS_C_IDLE;
            cal_done    <= 1'b1;
            cal_timeout <= 1'b0;
          end
          else if (count >= MAX_CYC - 1)
          begin
            state       <= ARCS_C_IDLE;
            cal_done    <= 1'b1;
            cal_timeout <= 1'b1;
          end
        end
        default: state <= ARCS_C_IDLE;
      endcase
    end
  end
endmodule : arcs_controller

/* sim/arcs_link_sva.sv */
`timescale 1ns/1ps
`include "arcs_cfg.svh"
// =====================================================================
// link checker
module arcs_link_sva #(
  parameter int unsigned CAL_CYC = `ARCS_CAL_NOM_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link signals
  input wire logic dev_reset_low_oe,
  input wire logic ctl_reset_low_oe,
  input wire logic calibration_reset_n,
  input wire logic over_range_flag,
  input wire logic output_clock,
  input wire logic sdo_pull_high
);
  logic [31:0] cal_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // cycles since the reset line went high
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || !calibration_reset_n)
      cal_cnt <= 32'h0;
    else if (cal_cnt != 32'hFFFFFFFF)
      cal_cnt <= cal_cnt + 32'h1;
  end
  AST_POR_LOW: assert property ($rose(rst_b) |-> ##[1:2] !calibration_reset_n)
    else $error("line not pulled low after reset");
  AST_POR_FREE: assert property ($rose(rst_b) |-> ##[1:40] !dev_reset_low_oe)
    else $error("device never releases line");
  AST_FLAG_SET: assert property (!calibration_reset_n |=> over_range_flag)
    else $error("flag low after line low");
  AST_FLAG_CAL: assert property ((cal_cnt != 0 && cal_cnt < CAL_CYC - 1) |-> over_range_flag)
    else $error("flag dropped during calibration");
  AST_CLK_LOW: assert property (!calibration_reset_n |=> !output_clock)
    else $error("output clock high while line low");
  AST_CLK_RUN: assert property ($rose(calibration_reset_n) |-> ##[1:4] output_clock)
    else $error("output clock did not resume");
  AST_PULSE: assert property ($rose(ctl_reset_low_oe) |=> !ctl_reset_low_oe)
    else $error("controller pulse width wrong");
  AST_SDO: assert property (sdo_pull_high)
    else $error("serial data out not high");
endmodule : arcs_link_sva

/* sim/adc_reset_calibration_sequencer_tb.sv */
`timescale 1ns/1ps
// =====================================================================
// bench top
module adc_reset_calibration_sequencer_tb;
  import arcs_pkg::*;
  localparam int unsigned CAL = 50;
  localparam int unsigned MAXC = 100;
  localparam int unsigned LOCK = 20;
  logic       core_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       div2_enable = 1'b0;
  logic       recal_req = 1'b0;
  logic [9:0] sample_code = 10'h100;
  logic [9:0] result_code;
  logic       result_valid, cal_busy, dll_locked, cal_fail;
  logic       cal_done, cal_timeout, spi_allowed;
  int         err_total = 0;
  int         n_tests = 0;
  int         lat;
  int         toggles;
  logic       oc_prev;
  arcs_link_if link();
  arcs_device #(.CAL_CYC(CAL), .LOCK_CYC(LOCK), .POR_CYC(16)) arcs_device_inst (
    .core_clk(core_clk), .rst_b(rst_b), .link(link.device), .sample_code(sample_code),
    .div2_enable(div2_enable), .result_code(result_code), .result_valid(result_valid),
    .cal_busy(cal_busy), .dll_locked(dll_locked), .cal_fail(cal_fail));
  arcs_controller #(.MAX_CYC(MAXC), .PULSE_CYC(1)) arcs_controller_inst (
    .core_clk(core_clk), .rst_b(rst_b), .link(link.controller), .recal_req(recal_req),
    .cal_done(cal_done), .cal_timeout(cal_timeout), .spi_allowed(spi_allowed));
  arcs_link_sva #(.CAL_CYC(CAL)) arcs_link_sva_inst (
    .core_clk(core_clk), .rst_b(rst_b), .dev_reset_low_oe(link.dev_reset_low_oe),
    .ctl_reset_low_oe(link.ctl_reset_low_oe), .calibration_reset_n(link.calibration_reset_n),
    .over_range_flag(link.over_range_flag), .output_clock(link.output_clock),
    .sdo_pull_high(link.sdo_pull_high));
  // 100 ns clock
  always #50 core_clk = ~core_clk;
  // compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // verdict and end of run
  task finish_test;
    $display("mismatches=%0d compares=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // wait for calibration end or controller timeout
  task wait_done;
    for (int i = 0; i < 300 && cal_done !== 1'b1 && cal_timeout !== 1'b1; i++)
      @(posedge core_clk);
    #1;
  endtask : wait_done
  // request recalibration and follow the line
  task recal;
    @(posedge core_clk);
    recal_req <= 1'b1;
    @(posedge core_clk);
    recal_req <= 1'b0;
    #1;
    check(link.calibration_reset_n, 1'b0);
    @(posedge core_clk);
    #1;
    check(link.over_range_flag, 1'b1);
    check(link.output_clock, 1'b0);
    check(cal_done, 1'b0);
  endtask : recal
  // main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check(link.calibration_reset_n, 1'b0);
    check(spi_allowed, 1'b0);
    check(link.over_range_flag, 1'b1);
    check(link.output_clock, 1'b0);
    check(cal_busy, 1'b1);
    wait_done();
    check(cal_done, 1'b1);
    check(cal_busy, 1'b0);
    check(cal_timeout, 1'b0);
    check(spi_allowed, 1'b1);
    check(cal_fail, 1'b0);
    check(link.over_range_flag, 1'b0);
    @(posedge core_clk);
    sample_code <= 10'h2A5;
    lat = 0;
    for (int i = 0; i < 20 && result_code !== 10'h2A5; i++)
    begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    // 15 half-sample stages after capture, plus launch edge and phase
    check(lat inside {[16:17]}, 1'b1);
    check(result_valid, 1'b1);
    recal();
    wait_done();
    check(cal_done, 1'b1);
    check(link.over_range_flag, 1'b0);
    @(posedge core_clk);
    div2_enable <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check(dll_locked, 1'b0);
    for (int i = 0; i < 2 * LOCK + 10 && dll_locked !== 1'b1; i++)
      #100;
    check(dll_locked, 1'b1);
    // divided clock: output clock toggles every other edge
    toggles = 0;
    for (int i = 0; i < 8; i++)
    begin
      oc_prev = link.output_clock;
      @(posedge core_clk);
      #1;
      if (link.output_clock !== oc_prev)
        toggles++;
    end
    check(toggles, 4);
    @(posedge core_clk);
    sample_code <= 10'h3FF;
    // divided rate doubles the pipeline delay in edges
    repeat (36) @(posedge core_clk);
    #1;
    check(link.over_range_flag, 1'b1);
    check(result_code, 10'h3FF);
    recal();
    wait_done();
    check(cal_timeout, 1'b1);
    check(link.over_range_flag, 1'b1);
    finish_test();
  end
  // watchdog
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    finish_test();
  end
endmodule : adc_reset_calibration_sequencer_tb
